// ===== hw/dps_defs.vh
// Constants for the drive power state object block: object indices,
// subindices, reset values, bit positions and state codes.
// Assumes it is included once per compilation unit by its bare name.
`ifndef DPS_DEFS_VH
`define DPS_DEFS_VH

// Object indices and subindices.
`define DPS_IDX_LOADER 16'h4042
`define DPS_IDX_ERROR 16'h603F
`define DPS_IDX_COMMAND 16'h6040
`define DPS_IDX_STATE 16'h6041
`define DPS_IDX_SPEED 16'h6042
`define DPS_SUB_COUNT 8'h00
`define DPS_SUB_VERSION 8'h01
`define DPS_SUB_FIELDBUS 8'h02
`define DPS_SUB_HWGROUP 8'h03

// Reset values.
`define DPS_RST_ENTRY_COUNT 8'h03
`define DPS_RST_LOADER 32'h00000000
`define DPS_RST_ERROR 16'h0000
`define DPS_RST_COMMAND 16'h0000
`define DPS_RST_STATE 16'h0000
`define DPS_RST_SPEED 16'h00C8

// Command word bit positions.
`define DPS_CMD_SWITCH_ON 0
`define DPS_CMD_ENABLE_VOLTAGE 1
`define DPS_CMD_QUICK_STOP_N 2
`define DPS_CMD_ENABLE_OPERATION 3
`define DPS_CMD_FAULT_RESET 7
`define DPS_CMD_HALT 8

// State word bit positions.
`define DPS_ST_WARNING 7
`define DPS_ST_SYNC 8
`define DPS_ST_HOST_CONTROL 9
`define DPS_ST_ARRIVED 10
`define DPS_ST_CLAMP 11
`define DPS_ST_CLOSED_LOOP 15

// Power state machine codes.
`define DPS_PS_NOT_READY 3'h0
`define DPS_PS_SWITCH_ON_DISABLED 3'h1
`define DPS_PS_READY 3'h2
`define DPS_PS_SWITCHED_ON 3'h3
`define DPS_PS_OPERATION 3'h4
`define DPS_PS_QUICK_STOP 3'h5
`define DPS_PS_FAULT_REACTION 3'h6
`define DPS_PS_FAULT 3'h7

// Operating modes in which halt is honoured.
`define DPS_MODE_PROFILE_POS 8'h01
`define DPS_MODE_VELOCITY 8'h02
`define DPS_MODE_PROFILE_VEL 8'h03
`define DPS_MODE_PROFILE_TRQ 8'h04
`define DPS_MODE_INTERP_POS 8'h07

`endif

// ===== hw/dps_objects.v
// Drive power state object block: loader identification, last error,
// command word, state word with power state machine, speed setpoint.
// Assumes a fieldbus protocol engine on the same clock presents object
// accesses (service or process data alike) on the access port.
`timescale 1ns/1ns
`include "dps_defs.vh"

// Contract
// - Version word: major high, minor low, read-only.
// - Fieldbus-support word mirrors module-availability bits.
// - Error code: low 16 bits newest history.
// - Command bit 0 one: toward switched on.
// - Command bit 1 one: toward voltage enabled.
// - Command bit 2 zero: enter quick stop.
// - Command bit 3 one: toward operation enabled.
// - Command bit 7: clear error or warning.
// - Command bit 8: halt in listed modes only.
// - Mode-specific bits follow selected operating mode.
// - State bit 0: ready to switch on.
// - State bit 1: switched on.
// - State bit 2: operation enabled.
// - State bit 5 low during quick stop.
// - State bit 6: switch on disabled.
// - State bit 8: synchronised with fieldbus.
// - State bit 9 one unless special modes.
// - State bit 15: enabled with closed loop.
// - Encode not-ready, disabled, ready state masks.
// - Encode switched-on, enabled, quick-stop masks.
// - Bit 3 error; fault reaction and fault masks.
// - Signed 16-bit speed setpoint, preset 00C8.
module dps_objects (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_i,
    // Object access port.
    input wire acc_req_i,
    input wire acc_wr_i,
    input wire [15:0] acc_index_i,
    input wire [7:0] acc_sub_i,
    input wire [31:0] acc_wdata_i,
    output reg acc_ack_o,
    output reg acc_abort_o,
    output reg [31:0] acc_rdata_o,
    // Loader identification sources.
    input wire [15:0] loader_major_i,
    input wire [15:0] loader_minor_i,
    input wire [31:0] fieldbus_avail_i,
    input wire [31:0] loader_hw_group_i,
    // Drive status sources.
    input wire [31:0] error_newest_i,
    input wire fault_event_i,
    input wire fault_reaction_done_i,
    input wire warning_event_i,
    input wire voltage_applied_i,
    input wire sync_i,
    input wire special_mode_i,
    input wire closed_loop_i,
    input wire setpoint_arrived_i,
    input wire range_clamp_i,
    input wire [1:0] mode_state_bits_i,
    input wire [7:0] op_mode_i,
    // Drive control outputs.
    output reg [2:0] power_state_o,
    output reg power_stage_on_o,
    output reg halt_o,
    output reg [3:0] mode_specific_bits_o,
    output reg [15:0] target_speed_o,
    output reg [15:0] state_word_o
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------

    // Command word as last written by the master.
    reg [15:0] command_word_ff;
    // Power state machine state.
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    // Sticky warning, cleared by fault reset.
    reg warning_ff;
    // Previous fault reset bit, so a reset acts on its rising edge.
    reg fault_reset_d_ff;
    // Speed setpoint, signed user units.
    reg [15:0] speed_ff;
    // Registered copies of the read-only sources.
    reg [31:0] loader_version_ff;
    reg [31:0] loader_fieldbus_ff;
    reg [31:0] loader_hw_group_ff;
    reg [15:0] error_code_ff;

    // Decoded write strobes and the fault reset edge.
    wire wr_command;
    wire wr_speed;
    wire fault_reset_rise;
    wire [7:0] cur_bits; // Table bits of the present state.

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Bits 0-3 and 6 of the state word for a power state.
    function [7:0] state_bits;
        input [2:0] st;
        begin
            case (st)
                `DPS_PS_NOT_READY: state_bits = 8'h00;
                `DPS_PS_SWITCH_ON_DISABLED: state_bits = 8'h40;
                `DPS_PS_READY: state_bits = 8'h01;
                `DPS_PS_SWITCHED_ON: state_bits = 8'h03;
                `DPS_PS_OPERATION: state_bits = 8'h07;
                `DPS_PS_QUICK_STOP: state_bits = 8'h07;
                `DPS_PS_FAULT_REACTION: state_bits = 8'h0F;
                `DPS_PS_FAULT: state_bits = 8'h08;
                default: state_bits = 8'h00;
            endcase
        end
    endfunction

    // True when the access addresses the given object and subindex.
    function hit;
        input [15:0] idx;
        input [7:0] sub;
        input [15:0] want_idx;
        input [7:0] want_sub;
        begin
            hit = (idx == want_idx) && (sub == want_sub);
        end
    endfunction

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------

    // Only the two read/write objects accept writes.
    assign wr_command = acc_req_i && acc_wr_i &&
        hit(acc_index_i, acc_sub_i, `DPS_IDX_COMMAND, `DPS_SUB_COUNT);
    assign wr_speed = acc_req_i && acc_wr_i &&
        hit(acc_index_i, acc_sub_i, `DPS_IDX_SPEED, `DPS_SUB_COUNT);
    assign fault_reset_rise = command_word_ff[`DPS_CMD_FAULT_RESET] &&
        !fault_reset_d_ff;
    assign cur_bits = state_bits(state_ff);

    // Answer one cycle after the request. Unknown objects and writes to
    // read-only objects abort and leave stored contents untouched.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            acc_ack_o <= 1'b0;
            acc_abort_o <= 1'b0;
            acc_rdata_o <= 32'h00000000;
        end else begin
            acc_ack_o <= acc_req_i;
            acc_abort_o <= 1'b0;
            acc_rdata_o <= 32'h00000000;
            if (acc_req_i) begin
                if (hit(acc_index_i, acc_sub_i, `DPS_IDX_LOADER,
                        `DPS_SUB_COUNT)) begin
                    acc_rdata_o <= {24'h000000, `DPS_RST_ENTRY_COUNT};
                    acc_abort_o <= acc_wr_i;
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_LOADER,
                        `DPS_SUB_VERSION)) begin
                    acc_rdata_o <= loader_version_ff;
                    acc_abort_o <= acc_wr_i;
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_LOADER,
                        `DPS_SUB_FIELDBUS)) begin
                    acc_rdata_o <= loader_fieldbus_ff;
                    acc_abort_o <= acc_wr_i;
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_LOADER,
                        `DPS_SUB_HWGROUP)) begin
                    acc_rdata_o <= loader_hw_group_ff;
                    acc_abort_o <= acc_wr_i;
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_ERROR,
                        `DPS_SUB_COUNT)) begin
                    acc_rdata_o <= {16'h0000, error_code_ff};
                    acc_abort_o <= acc_wr_i;
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_STATE,
                        `DPS_SUB_COUNT)) begin
                    acc_rdata_o <= {16'h0000, state_word_o};
                    acc_abort_o <= acc_wr_i;
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_COMMAND,
                        `DPS_SUB_COUNT)) begin
                    acc_rdata_o <= {16'h0000, command_word_ff};
                end else if (hit(acc_index_i, acc_sub_i, `DPS_IDX_SPEED,
                        `DPS_SUB_COUNT)) begin
                    // Sign-extended, since the setpoint is signed.
                    acc_rdata_o <= {{16{speed_ff[15]}}, speed_ff};
                end else begin
                    // No such object: abort, read data zero.
                    acc_abort_o <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Writable objects and read-only mirrors
    // ------------------------------------------------------------

    // Writes take the low 16 bits; mirrors refresh every cycle.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            command_word_ff <= `DPS_RST_COMMAND;
            speed_ff <= `DPS_RST_SPEED;
            fault_reset_d_ff <= 1'b0;
            loader_version_ff <= `DPS_RST_LOADER;
            loader_fieldbus_ff <= `DPS_RST_LOADER;
            loader_hw_group_ff <= `DPS_RST_LOADER;
            error_code_ff <= `DPS_RST_ERROR;
        end else begin
            if (wr_command) begin
                command_word_ff <= acc_wdata_i[15:0];
            end
            if (wr_speed) begin
                speed_ff <= acc_wdata_i[15:0];
            end
            fault_reset_d_ff <= command_word_ff[`DPS_CMD_FAULT_RESET];
            loader_version_ff <= {loader_major_i, loader_minor_i};
            loader_fieldbus_ff <= fieldbus_avail_i;
            loader_hw_group_ff <= loader_hw_group_i;
            error_code_ff <= error_newest_i[15:0];
        end
    end

    // ------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------

    // A fault event preempts every state except the fault states. The
    // enable bits are checked from the most drastic request down, so a
    // dropped voltage bit wins over a dropped switch-on bit.
    always @* begin
        nxt_state = state_ff;
        if (fault_event_i && state_ff != `DPS_PS_FAULT_REACTION &&
                state_ff != `DPS_PS_FAULT) begin
            nxt_state = `DPS_PS_FAULT_REACTION;
        end else begin
            case (state_ff)
                `DPS_PS_NOT_READY: begin
                    // Self-test is assumed done once out of reset.
                    nxt_state = `DPS_PS_SWITCH_ON_DISABLED;
                end
                `DPS_PS_SWITCH_ON_DISABLED: begin
                    if (command_word_ff[`DPS_CMD_ENABLE_VOLTAGE] &&
                            command_word_ff[`DPS_CMD_QUICK_STOP_N]) begin
                        nxt_state = `DPS_PS_READY;
                    end
                end
                `DPS_PS_READY: begin
                    if (!command_word_ff[`DPS_CMD_ENABLE_VOLTAGE] ||
                            !command_word_ff[`DPS_CMD_QUICK_STOP_N]) begin
                        nxt_state = `DPS_PS_SWITCH_ON_DISABLED;
                    end else if (command_word_ff[`DPS_CMD_SWITCH_ON]) begin
                        nxt_state = `DPS_PS_SWITCHED_ON;
                    end
                end
                `DPS_PS_SWITCHED_ON: begin
                    if (!command_word_ff[`DPS_CMD_ENABLE_VOLTAGE] ||
                            !command_word_ff[`DPS_CMD_QUICK_STOP_N]) begin
                        nxt_state = `DPS_PS_SWITCH_ON_DISABLED;
                    end else if (!command_word_ff[`DPS_CMD_SWITCH_ON]) begin
                        nxt_state = `DPS_PS_READY;
                    end else if (
                            command_word_ff[`DPS_CMD_ENABLE_OPERATION]) begin
                        nxt_state = `DPS_PS_OPERATION;
                    end
                end
                `DPS_PS_OPERATION: begin
                    if (!command_word_ff[`DPS_CMD_ENABLE_VOLTAGE]) begin
                        nxt_state = `DPS_PS_SWITCH_ON_DISABLED;
                    end else if (!command_word_ff[`DPS_CMD_QUICK_STOP_N]) begin
                        nxt_state = `DPS_PS_QUICK_STOP;
                    end else if (!command_word_ff[`DPS_CMD_SWITCH_ON]) begin
                        nxt_state = `DPS_PS_READY;
                    end else if (
                            !command_word_ff[`DPS_CMD_ENABLE_OPERATION]) begin
                        nxt_state = `DPS_PS_SWITCHED_ON;
                    end
                end
                `DPS_PS_QUICK_STOP: begin
                    // Leave quick stop only by dropping the voltage bit.
                    if (!command_word_ff[`DPS_CMD_ENABLE_VOLTAGE]) begin
                        nxt_state = `DPS_PS_SWITCH_ON_DISABLED;
                    end
                end
                `DPS_PS_FAULT_REACTION: begin
                    if (fault_reaction_done_i) begin
                        nxt_state = `DPS_PS_FAULT;
                    end
                end
                `DPS_PS_FAULT: begin
                    // Only a rising fault reset edge clears the fault.
                    if (fault_reset_rise) begin
                        nxt_state = `DPS_PS_SWITCH_ON_DISABLED;
                    end
                end
                default: nxt_state = `DPS_PS_NOT_READY;
            endcase
        end
    end

    // State register and sticky warning; a new warning in the cycle of
    // a fault reset edge survives, so no warning is lost.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_ff <= `DPS_PS_NOT_READY;
            warning_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (warning_event_i) begin
                warning_ff <= 1'b1;
            end else if (fault_reset_rise) begin
                warning_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // State word and drive controls, registered from current state, command word and setpoint.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_word_o <= `DPS_RST_STATE;
            power_state_o <= `DPS_PS_NOT_READY;
            power_stage_on_o <= 1'b0;
            halt_o <= 1'b0;
            mode_specific_bits_o <= 4'h0;
            target_speed_o <= `DPS_RST_SPEED;
        end else begin
            // Bits 0-3 and 6 from the state table.
            state_word_o[3:0] <= cur_bits[3:0];
            state_word_o[6] <= cur_bits[6];
            state_word_o[4] <= voltage_applied_i;
            state_word_o[5] <= (state_ff != `DPS_PS_QUICK_STOP);
            state_word_o[`DPS_ST_WARNING] <= warning_ff;
            state_word_o[`DPS_ST_SYNC] <= sync_i;
            state_word_o[`DPS_ST_HOST_CONTROL] <= !special_mode_i;
            state_word_o[`DPS_ST_ARRIVED] <= setpoint_arrived_i;
            state_word_o[`DPS_ST_CLAMP] <= range_clamp_i;
            state_word_o[13:12] <= mode_state_bits_i;
            state_word_o[14] <= 1'b0;
            state_word_o[`DPS_ST_CLOSED_LOOP] <=
                (state_ff == `DPS_PS_OPERATION) && closed_loop_i;
            power_state_o <= state_ff;
            // Power stage runs while enabled or braking in quick stop.
            power_stage_on_o <= (state_ff == `DPS_PS_OPERATION) ||
                (state_ff == `DPS_PS_QUICK_STOP);
            halt_o <= command_word_ff[`DPS_CMD_HALT] &&
                (op_mode_i == `DPS_MODE_PROFILE_POS ||
                 op_mode_i == `DPS_MODE_VELOCITY ||
                 op_mode_i == `DPS_MODE_PROFILE_VEL ||
                 op_mode_i == `DPS_MODE_PROFILE_TRQ ||
                 op_mode_i == `DPS_MODE_INTERP_POS);
            // Bits 4-6 and 9 go raw to the mode engines.
            mode_specific_bits_o <= {command_word_ff[9],
                command_word_ff[6:4]};
            target_speed_o <= speed_ff;
        end
    end

endmodule

// ===== dv/dps_objects_chk.sv
// Concurrent checks on the drive power state object block's ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`include "dps_defs.vh"

module dps_objects_chk (
    // Clock and reset.
    input wire clk_sys_i,
    input wire rst_i,
    // Access port.
    input wire acc_req_i,
    input wire acc_wr_i,
    input wire [15:0] acc_index_i,
    input wire acc_ack_o,
    input wire acc_abort_o,
    // Status sources and results.
    input wire closed_loop_i,
    input wire [2:0] power_state_o,
    input wire [15:0] target_speed_o,
    input wire [15:0] state_word_o
);
    // -----------------------------------------------------------------
    // State word masks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_disabled_mask:
    assert property (power_state_o == `DPS_PS_SWITCH_ON_DISABLED |->
        (state_word_o & 16'h004F) == 16'h0040) else $error("bad mask");
    a_ready_mask:
    assert property (power_state_o == `DPS_PS_READY |->
        (state_word_o & 16'h006F) == 16'h0021) else $error("bad mask");
    a_switched_mask:
    assert property (power_state_o == `DPS_PS_SWITCHED_ON |->
        (state_word_o & 16'h006F) == 16'h0023) else $error("bad mask");
    a_enabled_mask:
    assert property (power_state_o == `DPS_PS_OPERATION |->
        (state_word_o & 16'h006F) == 16'h0027) else $error("bad mask");
    a_quick_mask:
    assert property (power_state_o == `DPS_PS_QUICK_STOP |->
        (state_word_o & 16'h006F) == 16'h0007) else $error("bad mask");
    a_fault_masks:
    assert property (power_state_o == `DPS_PS_FAULT |->
        (state_word_o & 16'h004F) == 16'h0008) else $error("bad mask");
    a_closed_loop:
    assert property (state_word_o[15] |-> $past(closed_loop_i) &&
        power_state_o == `DPS_PS_OPERATION) else $error("bad b15");
    // -----------------------------------------------------------------
    // Access port timing, refusals and speed preset
    // -----------------------------------------------------------------
    a_ack_timing:
    assert property (!$past(rst_i) |-> acc_ack_o == $past(acc_req_i))
        else $error("late ack");
    a_ro_refused:
    assert property (acc_req_i && acc_wr_i && (acc_index_i == 16'h6041 ||
        acc_index_i == 16'h603F) |=> acc_abort_o) else $error("no abort");
    a_speed_preset:
    assert property ($fell(rst_i) |-> target_speed_o == 16'h00C8)
        else $error("bad preset");
endmodule

bind dps_objects dps_objects_chk chk_u (.clk_sys_i(clk_sys_i),
    .rst_i(rst_i), .acc_req_i(acc_req_i), .acc_wr_i(acc_wr_i),
    .acc_index_i(acc_index_i), .acc_ack_o(acc_ack_o),
    .acc_abort_o(acc_abort_o), .closed_loop_i(closed_loop_i),
    .power_state_o(power_state_o), .target_speed_o(target_speed_o),
    .state_word_o(state_word_o));

// ===== dv/dps_master_model.sv
// Behavioural fieldbus master issuing object accesses to the drive.
// Assumes the drive answers exactly one cycle after taking a request.
`timescale 1ns/1ns

module dps_master_model (
    // Clock.
    input wire clk_sys_i,
    // Requests towards the drive.
    output logic req_o,
    output logic wr_o,
    output logic [15:0] index_o,
    output logic [7:0] sub_o,
    output logic [31:0] wdata_o,
    // Answers from the drive.
    input wire ack_i,
    input wire abort_i,
    input wire [31:0] rdata_i
);
    // Idle bus at time zero.
    initial {req_o, wr_o, index_o, sub_o, wdata_o} = 58'h0;
    // Request is a one-cycle pulse; qualifiers hold until the answer.
    task automatic xfer(input logic wr, input logic [15:0] idx,
        input logic [7:0] sub, input logic [31:0] wd,
        output logic ack, output logic ab, output logic [31:0] rd);
        @(posedge clk_sys_i);
        req_o <= 1'b1;
        wr_o <= wr;
        index_o <= idx;
        sub_o <= sub;
        wdata_o <= wd;
        @(posedge clk_sys_i);
        req_o <= 1'b0;
        @(posedge clk_sys_i);
        ack = ack_i;
        ab = abort_i;
        rd = rdata_i;
    endtask
endmodule

// ===== dv/dps_objects_tb.sv
// Self-checking bench for the drive power state object block.
// Assumes the master model drives the access port and the checker is bound.
`timescale 1ns/1ns
`include "dps_defs.vh"

module dps_objects_tb;
    typedef struct packed {
        logic wr;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [31:0] wd;
        logic ab;
        logic [31:0] rd;
    } dps_row_t;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic fault_i = 1'b0, done_i = 1'b0, warn_i = 1'b0, volt_i = 1'b0;
    logic sync_i = 1'b1, special_i = 1'b0, loop_i = 1'b1, clamp_i = 1'b0;
    logic arrived_i = 1'b1;
    logic [1:0] msb_i = 2'b10;
    logic [7:0] mode_i = 8'h00;
    logic req, wr, ack, abort, ok, ab, halt, stage;
    logic [15:0] idx, speed, word;
    logic [7:0] sub;
    logic [31:0] wd, rdata, rd;
    logic [2:0] ps;
    logic [3:0] mbits;
    logic [18:0] walk [0:10];
    dps_row_t rows [0:12];
    integer n_fail = 0;
    integer tests_run = 0;
    integer i;
    always #25 clk_sys_i = ~clk_sys_i;
    dps_objects dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .acc_req_i(req), .acc_wr_i(wr), .acc_index_i(idx), .acc_sub_i(sub),
        .acc_wdata_i(wd), .acc_ack_o(ack), .acc_abort_o(abort),
        .acc_rdata_o(rdata), .loader_major_i(16'h0004),
        .loader_minor_i(16'h0002), .fieldbus_avail_i(32'h00000005),
        .loader_hw_group_i(32'h000000A5), .error_newest_i(32'h12348130),
        .fault_event_i(fault_i), .fault_reaction_done_i(done_i),
        .warning_event_i(warn_i), .voltage_applied_i(volt_i),
        .sync_i(sync_i), .special_mode_i(special_i), .closed_loop_i(loop_i),
        .setpoint_arrived_i(arrived_i), .range_clamp_i(clamp_i),
        .mode_state_bits_i(msb_i), .op_mode_i(mode_i),
        .power_state_o(ps), .power_stage_on_o(stage), .halt_o(halt),
        .mode_specific_bits_o(mbits), .target_speed_o(speed),
        .state_word_o(word));
    dps_master_model mst_u (.clk_sys_i(clk_sys_i), .req_o(req), .wr_o(wr),
        .index_o(idx), .sub_o(sub), .wdata_o(wd), .ack_i(ack),
        .abort_i(abort), .rdata_i(rdata));
    // Low state word bits per state code, bit 5 high except in quick stop.
    function automatic logic [15:0] low_bits(input logic [2:0] s);
        case (s)
            `DPS_PS_SWITCH_ON_DISABLED: low_bits = 16'h0060;
            `DPS_PS_READY: low_bits = 16'h0021;
            `DPS_PS_SWITCHED_ON: low_bits = 16'h0023;
            `DPS_PS_OPERATION: low_bits = 16'h0027;
            `DPS_PS_QUICK_STOP: low_bits = 16'h0007;
            `DPS_PS_FAULT_REACTION: low_bits = 16'h002F;
            `DPS_PS_FAULT: low_bits = 16'h0028;
            default: low_bits = 16'h0020;
        endcase
    endfunction
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Command write, then edges for cascaded moves.
    task automatic put_cmd(input logic [15:0] c);
        mst_u.xfer(1'b1, 16'h6040, 8'h00, {16'h0000, c}, ok, ab, rd);
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task automatic pulse(input integer k);
        @(posedge clk_sys_i);
        {fault_i, done_i, warn_i} <= 3'b100 >> k;
        @(posedge clk_sys_i);
        {fault_i, done_i, warn_i} <= 3'b000;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask
    task give_verdict;
        $display("comparisons=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog at about seventeen times the expected run.
    initial begin
        #(4000 * 50);
        n_fail = n_fail + 1;
        give_verdict;
    end
    initial begin
        rows[0] = {1'b0, 16'h4042, 8'h00, 32'h0, 1'b0, 32'h00000003};
        rows[1] = {1'b0, 16'h4042, 8'h01, 32'h0, 1'b0, 32'h00040002};
        rows[2] = {1'b0, 16'h4042, 8'h02, 32'h0, 1'b0, 32'h00000005};
        rows[3] = {1'b0, 16'h4042, 8'h03, 32'h0, 1'b0, 32'h000000A5};
        rows[4] = {1'b0, 16'h603F, 8'h00, 32'h0, 1'b0, 32'h00008130};
        rows[5] = {1'b0, 16'h6042, 8'h00, 32'h0, 1'b0, 32'h000000C8};
        rows[6] = {1'b1, 16'h6042, 8'h00, 32'hFF38, 1'b0, 32'h0};
        rows[7] = {1'b0, 16'h6042, 8'h00, 32'h0, 1'b0, 32'hFFFFFF38};
        rows[8] = {1'b1, 16'h603F, 8'h00, 32'h1, 1'b1, 32'h00008130};
        rows[9] = {1'b1, 16'h4042, 8'h01, 32'h1, 1'b1, 32'h00040002};
        rows[10] = {1'b1, 16'h6041, 8'h00, 32'h1, 1'b1, {16'h0, word}};
        rows[11] = {1'b0, 16'h1234, 8'h00, 32'h0, 1'b1, 32'h0};
        rows[12] = {1'b0, 16'h6040, 8'h01, 32'h0, 1'b1, 32'h0};
        walk[0] = {16'h0006, `DPS_PS_READY};
        walk[1] = {16'h0004, `DPS_PS_SWITCH_ON_DISABLED};
        walk[2] = {16'h0006, `DPS_PS_READY};
        walk[3] = {16'h0007, `DPS_PS_SWITCHED_ON};
        walk[4] = {16'h000F, `DPS_PS_OPERATION};
        walk[5] = {16'h0007, `DPS_PS_SWITCHED_ON};
        walk[6] = {16'h000F, `DPS_PS_OPERATION};
        walk[7] = {16'h000E, `DPS_PS_READY};
        walk[8] = {16'h000F, `DPS_PS_OPERATION};
        walk[9] = {16'h000B, `DPS_PS_QUICK_STOP};
        walk[10] = {16'h0001, `DPS_PS_SWITCH_ON_DISABLED};
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        rows[10].rd = {16'h0000, word};
        for (i = 0; i <= 12; i = i + 1) begin
            mst_u.xfer(rows[i].wr, rows[i].idx, rows[i].sub, rows[i].wd,
                ok, ab, rd);
            chk_val(ok, 1'b1);
            chk_val(ab, rows[i].ab);
            if (!(rows[i].wr && !rows[i].ab))
                chk_val(rd, rows[i].rd);
        end
        chk_val(speed, 16'hFF38);
        $display("object table done");
        volt_i <= 1'b1;
        clamp_i <= 1'b1;
        for (i = 0; i <= 10; i = i + 1) begin
            put_cmd(walk[i][18:3]);
            chk_val(ps, walk[i][2:0]);
            chk_val(stage, walk[i][2:0] == `DPS_PS_OPERATION ||
                walk[i][2:0] == `DPS_PS_QUICK_STOP);
            chk_val(word & 16'hFF7F, low_bits(walk[i][2:0]) | 16'h2F10 |
                {walk[i][2:0] == `DPS_PS_OPERATION, 15'h0});
        end
        $display("power state walk done");
        pulse(0);
        chk_val(word & 16'h006F, low_bits(`DPS_PS_FAULT_REACTION));
        pulse(1);
        chk_val(ps, `DPS_PS_FAULT);
        pulse(2);
        chk_val(word[7], 1'b1);
        put_cmd(16'h0080);
        chk_val(ps, `DPS_PS_SWITCH_ON_DISABLED);
        chk_val(word[7], 1'b0);
        $display("fault and reset done");
        put_cmd(16'h0150);
        chk_val(mbits, 4'h5);
        for (i = 0; i < 8; i = i + 1) begin
            @(posedge clk_sys_i);
            mode_i <= i;
            special_i <= i[0];
            msb_i <= i[1:0];
            arrived_i <= i[2];
            repeat (3) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            chk_val(halt, i != 0 && i != 5 && i != 6);
            chk_val(word & 16'h3600,
                {2'b00, i[1:0], 1'b0, i[2], ~i[0], 9'h000});
        end
        $display("halt and mode bits done");
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(negedge clk_sys_i);
        chk_val(speed, 16'h00C8);
        chk_val(word, 16'h0000);
        mst_u.xfer(1'b0, 16'h6040, 8'h00, 32'h0, ok, ab, rd);
        chk_val(rd, 32'h00000000);
        chk_val(ps, `DPS_PS_SWITCH_ON_DISABLED);
        $display("mid-run reset done");
        give_verdict;
    end
endmodule
